// ===== design/sps_pkg.sv
// shared constants and types for the sensor parameter structure bank
package sps_pkg;
    // clock rate and rate-switch settling time
    localparam int CLK_MHZ = 125;
    localparam int RATE_SETTLE_NS = 2000;
    localparam int RATE_SETTLE_CYC = (RATE_SETTLE_NS * CLK_MHZ + 999) / 1000;
    // bus byte addresses of the two structures and the type selector
    localparam logic [7:0] INFO_BASE = 8'h00;
    localparam logic [7:0] CFG_BASE = 8'h40;
    localparam logic [7:0] SEL_ADDR = 8'h80;
    // information structure word indices (byte address = base + 4 * index)
    localparam logic [3:0] IX_TYPE = 4'h0;
    localparam logic [3:0] IX_DRV = 4'h1;
    localparam logic [3:0] IX_REV = 4'h2;
    localparam logic [3:0] IX_PWR = 4'h3;
    localparam logic [3:0] IX_MAXRNG = 4'h4;
    localparam logic [3:0] IX_RES = 4'h6;
    localparam logic [3:0] IX_MAXRATE = 4'h8;
    localparam logic [3:0] IX_FRES = 4'ha;
    localparam logic [3:0] IX_FMAX = 4'hc;
    localparam logic [3:0] IX_EVT = 4'he;
    localparam logic [3:0] IX_MINRATE = 4'hf;
    // configuration structure word indices
    localparam logic [3:0] CX_RATE = 4'h0;
    localparam logic [3:0] CX_LAT = 4'h2;
    localparam logic [3:0] CX_SENS = 4'h4;
    localparam logic [3:0] CX_RANGE = 4'h6;
    // field positions inside one stored configuration entry
    localparam int F_RATE = 0;
    localparam int F_LAT = 16;
    localparam int F_SENS = 32;
    localparam int F_RNG = 48;
    // type id layout
    localparam logic [7:0] NONWAKE_MARK = 8'h10;
    localparam logic [7:0] WAKE_LIMIT = 8'h20;
    localparam logic [4:0] T_ACC = 5'h01;
    localparam logic [4:0] T_MAG = 5'h02;
    localparam logic [4:0] T_GYR = 5'h04;
    localparam logic [4:0] T_GRAV = 5'h09;
    localparam logic [4:0] T_LIN = 5'h0a;
    localparam logic [4:0] T_MAGU = 5'h0e;
    localparam logic [4:0] T_GYRU = 5'h10;
    // 14 range-request slots: 7 virtual sensors, non-wakeup then wakeup
    localparam int NSLOT = 14;
    localparam logic [3:0] WAKE_SLOT_OFS = 4'h7;
    localparam logic [13:0][1:0] SLOT_GRP = {
        2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0,
        2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
    // per physical sensor tables, index 0 accel, 1 gyro, 2 magnetometer
    localparam logic [2:0][15:0] MAX_RNG = {16'h0af0, 16'h0023, 16'h009d};
    localparam logic [2:0][15:0] DEF_RNG = {16'h04b0, 16'h07d0, 16'h0004};
    localparam logic [2:0][15:0] RES_BITS = {16'h0010, 16'h0010, 16'h0010};
    localparam logic [2:0][15:0] MAX_RATE = {16'h0064, 16'h00c8, 16'h00c8};
    localparam logic [2:0][7:0] MIN_RATE = {8'h01, 8'h01, 8'h01};
    localparam logic [2:0][7:0] PWR_TENTH_MA = {8'h02, 8'h09, 8'h02};
    localparam logic [7:0] DRV_ID = 8'h5a;  // arbitrary value
    localparam logic [7:0] DRV_REV = 8'h01;  // arbitrary value
    localparam logic [7:0] EVT_BYTES = 8'h08;
    // bus data-phase sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_W1 = 3'b001,
        ST_WD = 3'b010,
        ST_R1 = 3'b011,
        ST_R2 = 3'b100,
        ST_RD = 3'b101
    } sps_state_e;
endpackage

// ===== design/sps_cfg_mem.sv
// per-type configuration store with 16-bit lane writes and registered read
`timescale 1ns/10ps
module sps_cfg_mem #(
    parameter int AW = 6,
    parameter int LANES = 4
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [LANES-1:0] we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [16*LANES-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [16*LANES-1:0] rdata_o
);
    logic [16*LANES-1:0] mem_r [2**AW];

    ////////////////////////////////////////////////////////////////////
    // lane writes, entries start undefined until software writes them
    always_ff @(posedge mclk_i) begin
        for (int l = 0; l < LANES; l++) begin
            if (ce_i && we_i[l]) begin
                mem_r[waddr_i][16*l +: 16] <= wdata_i[16*l +: 16];
            end
        end
    end

    // registered read port
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule

// ===== design/sps_param_bank.sv
// sensor information and configuration structures behind an ahb-lite slave
//
// Overview of operation
// [RULE1] unsupported sensor type reads zero in every information field
// [RULE2] max range is a fixed rounded-up integer for the top range setting
// [RULE3] resolution is reported as a bit count
// [RULE4] byte 0 echoes requested type, bit 4 set for non-wakeup types
// [RULE5] reserved-fifo field is reserved bytes divided by packet size
// [RULE6] max-fifo field is total fifo bytes divided by packet size
// [RULE7] event size is whole packet length including the type byte
// [RULE8] sample rate takes requested hertz, reads back actual rate
// [RULE9] zero latency means no batching; nonzero latency needs nonzero rate
// [RULE10] rate switches after a short delay, actual within 90% to 210%
// [RULE11] host waits for rate-changed event to know switch completed
// [RULE12] latency write applies at once and updates the running timer
// [RULE13] latency written to zero from nonzero acts as a flush request
// [RULE14] range writes steer the physical sensor; zero asks for default
// [RULE15] output scale follows range, data width and signedness
// [RULE16] shared physical sensor uses largest nonzero requested range
// [RULE17] accel/gravity/linear, gyro pair and magnetometer pair share sensors
// [RULE18] host watches range-changed event when changing an enabled sensor
// [RULE19] ranges are in earth gravities and degrees per second
// [RULE20] change sensitivity uses the same scaling as the data value
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
module sps_param_bank
    import sps_pkg::*;
#(
    parameter int FIFO_BYTES = 2048,
    parameter int FIFO_RES_BYTES = 512
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic flush_o,
    output logic [7:0] flush_type_o,
    output logic lat_upd_o,
    output logic [7:0] lat_type_o,
    output logic [15:0] lat_ms_o,
    output logic rate_chg_o,
    output logic [7:0] rate_type_o,
    output logic [15:0] rate_hz_o,
    output logic range_chg_o,
    output logic [15:0] acc_range_o,
    output logic [15:0] gyr_range_o,
    output logic [15:0] mag_range_o
);
    localparam logic [15:0] FRES_PKTS = 16'(FIFO_RES_BYTES / int'(EVT_BYTES));
    localparam logic [15:0] FMAX_PKTS = 16'(FIFO_BYTES / int'(EVT_BYTES));
    localparam int CW = $clog2(RATE_SETTLE_CYC + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(RATE_SETTLE_CYC - 1);

    if (FIFO_BYTES / int'(EVT_BYTES) > 65535 || FIFO_RES_BYTES > FIFO_BYTES) begin : g_chk
        $error("fifo sizes do not fit the 16-bit packet count fields");
    end

    sps_state_e st_r;
    logic [7:0] addr_r;
    logic hit_r;
    logic [7:0] sel_r;
    logic [63:0] cfg_q;
    logic [3:0] mem_we;
    logic [15:0] wd16;
    logic [15:0] rng_r [NSLOT];
    logic [2:0][15:0] phys_r;
    logic [2:0][15:0] phys_nxt;
    logic pend_r;
    logic [7:0] pend_type_r;
    logic [15:0] pend_old_r;
    logic [15:0] pend_req_r;
    logic [CW-1:0] pend_cnt_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_val;
    logic acc;
    logic wr_go;
    logic wr_cfg;
    logic [3:0] ix;
    logic [6:0] sel_slot;
    logic sel_ok;
    logic [1:0] sel_grp;
    logic [3:0] sel_sidx;
    logic [15:0] rate_rb;
    logic [15:0] lat_rb;
    logic [15:0] rng_rb;

    ////////////////////////////////////////////////////////////////////
    // helpers: sharing map and the rate picker

    // {supported, group, slot}; types sharing one physical sensor map to one group
    function automatic logic [6:0] slot_of(input logic [7:0] t);
        logic [3:0] ofs;
        logic [6:0] s;
        ofs = t[5] ? WAKE_SLOT_OFS : 4'h0;
        s = 7'h00;
        if (t[7:6] == 2'b00) begin
            unique case (t[4:0])  // RULE17
                T_ACC: s = {1'b1, 2'h0, 4'h0 + ofs};
                T_GRAV: s = {1'b1, 2'h0, 4'h1 + ofs};
                T_LIN: s = {1'b1, 2'h0, 4'h2 + ofs};
                T_GYR: s = {1'b1, 2'h1, 4'h3 + ofs};
                T_GYRU: s = {1'b1, 2'h1, 4'h4 + ofs};
                T_MAG: s = {1'b1, 2'h2, 4'h5 + ofs};
                T_MAGU: s = {1'b1, 2'h2, 4'h6 + ofs};
                default: s = 7'h00;
            endcase
        end
        return s;
    endfunction

    // smallest power of two not below the request, or the request itself if zero or above 32768: 100% to 200% of it
    function automatic logic [15:0] pick_rate(input logic [15:0] r);
        logic [15:0] p;
        p = 16'h0001;
        for (int i = 0; i < 15; i++) begin
            if (p < r) begin
                p = p << 1;
            end
        end
        if (p < r || r == 16'h0000) begin
            p = r;
        end
        return p;
    endfunction

    assign sel_slot = slot_of(sel_r);
    assign sel_ok = sel_slot[6];
    assign sel_grp = sel_slot[5:4];
    assign sel_sidx = sel_slot[3:0];

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave: reads take two wait states, writes one

    assign acc = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = (st_r == ST_IDLE) || (st_r == ST_WD) || (st_r == ST_RD);
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_r;
    assign ix = addr_r[5:2];
    assign wr_go = ce_i && (st_r == ST_WD) && hit_r;
    assign wr_cfg = wr_go && (addr_r[7:6] == CFG_BASE[7:6]);
    assign wd16 = hwdata_i[15:0];

    // data-phase sequencer
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= ST_IDLE;
        end else if (ce_i) begin
            unique case (st_r)
                ST_W1: st_r <= ST_WD;
                ST_R1: st_r <= ST_R2;
                ST_R2: st_r <= ST_RD;
                ST_IDLE, ST_WD, ST_RD: st_r <= acc ? (hwrite_i ? ST_W1 : ST_R1) : ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // address phase capture; unmapped or non-word accesses are not hits
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_r <= 8'h00;
            hit_r <= 1'b0;
        end else if (ce_i && acc) begin
            addr_r <= haddr_i[7:0];
            hit_r <= (haddr_i[31:8] == 24'h000000) && (hsize_i == 3'b010)
                && (haddr_i[7:0] <= SEL_ADDR);
        end
    end

    // type selector
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_r <= 8'h00;
        end else if (wr_go && addr_r == SEL_ADDR) begin
            sel_r <= hwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration store, one entry per low six bits of the type id

    always_comb begin
        mem_we = 4'h0;
        if (wr_cfg) begin
            unique case (ix)
                CX_RATE: mem_we = 4'b0001;  // RULE8
                CX_LAT: mem_we = 4'b0010;  // RULE12
                CX_SENS: mem_we = 4'b0100;  // RULE20
                CX_RANGE: mem_we = 4'b1000;  // RULE19
                default: mem_we = 4'h0;
            endcase
        end
    end

    sps_cfg_mem #(
        .AW(6),
        .LANES(4)
    ) u_mem (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .we_i(mem_we),
        .waddr_i(sel_r[5:0]),
        .wdata_i({4{wd16}}),
        .raddr_i(sel_r[5:0]),
        .rdata_o(cfg_q)
    );

    ////////////////////////////////////////////////////////////////////
    // readback values that differ from what was written

    always_comb begin
        rate_rb = pick_rate(cfg_q[F_RATE +: 16]);  // RULE8
        if (pend_r && pend_type_r == sel_r) begin
            rate_rb = pend_old_r;  // RULE10
        end
        lat_rb = (cfg_q[F_RATE +: 16] == 16'h0000) ? 16'h0000 : cfg_q[F_LAT +: 16];  // RULE9
        rng_rb = sel_ok ? phys_r[sel_grp] : cfg_q[F_RNG +: 16];
    end

    // read data mux
    always_comb begin
        rd_val = 32'h00000000;
        if (addr_r == SEL_ADDR) begin
            rd_val = {24'h000000, sel_r};
        end else if (addr_r[7:6] == CFG_BASE[7:6]) begin
            unique case (ix)
                CX_RATE: rd_val = {16'h0000, rate_rb};
                CX_LAT: rd_val = {16'h0000, lat_rb};
                CX_SENS: rd_val = {16'h0000, cfg_q[F_SENS +: 16]};
                CX_RANGE: rd_val = {16'h0000, rng_rb};
                default: rd_val = 32'h00000000;
            endcase
        end else if (addr_r[7:6] == INFO_BASE[7:6] && sel_ok) begin  // RULE1
            unique case (ix)
                IX_TYPE: rd_val = {24'h000000,
                    (sel_r < WAKE_LIMIT) ? (sel_r | NONWAKE_MARK) : sel_r};  // RULE4
                IX_DRV: rd_val = {24'h000000, DRV_ID};
                IX_REV: rd_val = {24'h000000, DRV_REV};
                IX_PWR: rd_val = {24'h000000, PWR_TENTH_MA[sel_grp]};
                IX_MAXRNG: rd_val = {16'h0000, MAX_RNG[sel_grp]};  // RULE2
                IX_RES: rd_val = {16'h0000, RES_BITS[sel_grp]};  // RULE3
                IX_MAXRATE: rd_val = {16'h0000, MAX_RATE[sel_grp]};
                IX_FRES: rd_val = {16'h0000, FRES_PKTS};  // RULE5
                IX_FMAX: rd_val = {16'h0000, FMAX_PKTS};  // RULE6
                IX_EVT: rd_val = {24'h000000, EVT_BYTES};  // RULE7
                IX_MINRATE: rd_val = {24'h000000, MIN_RATE[sel_grp]};
                default: rd_val = 32'h00000000;
            endcase
        end
    end

    // read data register, loaded on the last wait cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_r <= 32'h00000000;
        end else if (ce_i && st_r == ST_R2) begin
            hrdata_r <= hit_r ? rd_val : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sample rate switch: old rate stands until the settle count runs out

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_r <= 1'b0;
            pend_type_r <= 8'h00;
            pend_old_r <= 16'h0000;
            pend_req_r <= 16'h0000;
            pend_cnt_r <= '0;
            rate_chg_o <= 1'b0;
            rate_type_o <= 8'h00;
            rate_hz_o <= 16'h0000;
        end else if (ce_i) begin
            rate_chg_o <= 1'b0;
            if (mem_we[0]) begin
                pend_r <= 1'b1;  // RULE10
                pend_type_r <= sel_r;
                pend_old_r <= rate_rb;
                pend_req_r <= wd16;
                pend_cnt_r <= SETTLE_LAST;
            end else if (pend_r) begin
                if (pend_cnt_r == '0) begin
                    pend_r <= 1'b0;
                    rate_chg_o <= 1'b1;  // RULE10
                    rate_type_o <= pend_type_r;
                    rate_hz_o <= pick_rate(pend_req_r);
                end else begin
                    pend_cnt_r <= pend_cnt_r - 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // batching latency: immediate timer update, flush on nonzero to zero

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lat_upd_o <= 1'b0;
            lat_type_o <= 8'h00;
            lat_ms_o <= 16'h0000;
            flush_o <= 1'b0;
            flush_type_o <= 8'h00;
        end else if (ce_i) begin
            lat_upd_o <= mem_we[1];  // RULE12
            flush_o <= mem_we[1] && wd16 == 16'h0000
                && cfg_q[F_LAT +: 16] != 16'h0000;  // RULE13
            if (mem_we[1]) begin
                lat_type_o <= sel_r;
                flush_type_o <= sel_r;
                lat_ms_o <= (cfg_q[F_RATE +: 16] == 16'h0000) ? 16'h0000 : wd16;  // RULE9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dynamic range: per virtual sensor requests, largest nonzero wins

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int s = 0; s < NSLOT; s++) begin
                rng_r[s] <= 16'h0000;
            end
        end else if (mem_we[3] && sel_ok) begin
            rng_r[sel_sidx] <= wd16;  // RULE14
        end
    end

    // choose the physical range of each group
    always_comb begin
        phys_nxt = '0;
        for (int s = 0; s < NSLOT; s++) begin
            if (rng_r[s] > phys_nxt[SLOT_GRP[s]]) begin
                phys_nxt[SLOT_GRP[s]] = rng_r[s];  // RULE16
            end
        end
        for (int g = 0; g < 3; g++) begin
            if (phys_nxt[g] == 16'h0000) begin
                phys_nxt[g] = DEF_RNG[g];  // RULE14
            end
        end
    end

    // data consumers rescale by range over 2^(bits-1) whenever this changes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phys_r <= DEF_RNG;
            range_chg_o <= 1'b0;
        end else if (ce_i) begin
            phys_r <= phys_nxt;
            range_chg_o <= (phys_nxt != phys_r);  // RULE15
        end
    end

    assign acc_range_o = phys_r[0];
    assign gyr_range_o = phys_r[1];
    assign mag_range_o = phys_r[2];

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i || !ce_i);

    sequence s_rd_wait;
        !hreadyout_o ##1 !hreadyout_o ##1 hreadyout_o;
    endsequence

    info_zero_a: assert property (st_r == ST_R2 && hit_r && addr_r < CFG_BASE && !sel_ok // RULE1
        |=> hrdata_o == 32'h00000000) else $error("unsupported type info not zero");
    echo_mark_a: assert property (st_r == ST_R2 && hit_r && addr_r == INFO_BASE // RULE4
        && sel_ok && sel_r < WAKE_LIMIT |=> hrdata_o[4] && hrdata_o[3:0] == $past(sel_r[3:0]))
        else $error("type echo wrong");
    read_wait_a: assert property (st_r == ST_R1 |-> s_rd_wait) // AHB-Lite read wait states
        else $error("read wait states wrong");
    rate_hold_a: assert property (mem_we[0] |=> pend_r [*2]) // RULE10
        else $error("rate switched at once");
    rate_window_a: assert property (rate_chg_o && rate_hz_o != 16'h0000 |-> // RULE10
        32'(rate_hz_o) * 10 >= 32'(pend_req_r) * 9 && 32'(rate_hz_o) * 10 <= 32'(pend_req_r) * 21)
        else $error("actual rate outside window");
    rate_done_a: assert property ($fell(pend_r) && !mem_we[0] |-> rate_chg_o) // RULE10
        else $error("rate change not reported");
    lat_apply_a: assert property (mem_we[1] |=> lat_upd_o && lat_type_o == $past(sel_r)) // RULE12
        else $error("latency not applied");
    flush_zero_a: assert property (mem_we[1] && wd16 == 16'h0000 // RULE13
        && cfg_q[F_LAT +: 16] != 16'h0000 |=> flush_o) else $error("no flush on zero latency");
    range_max_a: assert property (mem_we[3] && sel_ok && wd16 > phys_r[sel_grp] // RULE16
        |=> ##1 phys_r[$past(sel_grp, 2)] == $past(wd16, 2)) else $error("range not raised");
    range_dflt_a: assert property (rng_r[0] == 16'h0000 && rng_r[1] == 16'h0000 // RULE14
        && rng_r[2] == 16'h0000 && rng_r[7] == 16'h0000 && rng_r[8] == 16'h0000
        && rng_r[9] == 16'h0000 |=> acc_range_o == DEF_RNG[0]) else $error("default range");
    scale_evt_a: assert property (phys_r != $past(phys_r) |-> range_chg_o) // RULE15
        else $error("range change not flagged");
endmodule

// ===== dv/sps_host.sv
// host model: ahb-lite master, single word transfers
`timescale 1ns/10ps
module sps_host (
    input wire logic mclk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // idle bus
    initial begin
        {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
        hsize_o = 3'b010;
    end

    // one transfer, phases held until hready high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic ok);
        int n;
        logic rdy;
        n = 0;
        hsel_o <= 1'b1;
        htrans_o <= 2'b10;
        haddr_o <= {24'h0, a};
        hwrite_o <= w;
        do begin
            @(negedge mclk_i);
            rdy = hready_i;
            @(posedge mclk_i);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= wd;
        do begin
            @(negedge mclk_i);
            rdy = hready_i;
            rd = hrdata_i;
            @(posedge mclk_i);
            n++;
        end while (rdy !== 1'b1 && n < 40);
        ok = rdy;
    endtask
endmodule

// ===== dv/sps_param_bank_bench.sv
// parameter bank bench
`timescale 1ns/10ps
module sps_param_bank_bench;
    import sps_pkg::*;
    localparam int FB = 1024;
    localparam int FR = 256;
    typedef struct packed {logic [7:0] t; logic [3:0] ix; logic [31:0] e;} sps_irow_s;
    typedef struct packed {logic [7:0] t; logic [15:0] v; logic [1:0] g; logic [15:0] e;
        logic [7:0] rb;} sps_rrow_s;
    logic mclk_i, nrst_i, ce_i, hsel, hwrite, hready, hresp, ok;
    logic flush, lat_upd, rate_chg, range_chg;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] flush_type, lat_type, rate_type;
    logic [15:0] lat_ms, rate_hz, acc_r, gyr_r, mag_r, ph;
    int bad_count, total_checks, n_flush, n_lat, n_rate, n_rng, k;
    int rq[3] = '{100, 3, 200};
    sps_irow_s ir[15] = '{'{8'h01, IX_TYPE, 32'h11}, '{8'h21, IX_TYPE, 32'h21},
        '{8'h04, IX_TYPE, 32'h14}, '{8'h01, IX_DRV, 32'(DRV_ID)},
        '{8'h01, IX_REV, 32'(DRV_REV)}, '{8'h01, IX_PWR, 32'(PWR_TENTH_MA[0])},
        '{8'h01, IX_MAXRNG, 32'(MAX_RNG[0])}, '{8'h04, IX_MAXRNG, 32'(MAX_RNG[1])},
        '{8'h02, IX_MAXRNG, 32'(MAX_RNG[2])}, '{8'h01, IX_RES, 32'(RES_BITS[0])},
        '{8'h01, IX_MAXRATE, 32'(MAX_RATE[0])}, '{8'h01, IX_FRES, 32'(FR / 8)},
        '{8'h01, IX_FMAX, 32'(FB / 8)}, '{8'h21, IX_EVT, 32'h8},
        '{8'h01, IX_MINRATE, 32'(MIN_RATE[0])}};
    sps_rrow_s rr[7] = '{'{8'h01, 16'h10, 2'h0, 16'h10, 8'h09}, '{8'h0a, 16'h8, 2'h0, 16'h10, 8'h29},
        '{8'h01, 16'h0, 2'h0, 16'h8, 8'h09}, '{8'h0a, 16'h0, 2'h0, DEF_RNG[0], 8'h01},
        '{8'h10, 16'h1f4, 2'h1, 16'h1f4, 8'h04}, '{8'h04, 16'hfa, 2'h1, 16'h1f4, 8'h10},
        '{8'h0e, 16'h64, 2'h2, 16'h64, 8'h02}};

    sps_host host (.mclk_i(mclk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata));
    sps_param_bank #(.FIFO_BYTES(FB), .FIFO_RES_BYTES(FR)) DUT (.mclk_i(mclk_i),
        .nrst_i(nrst_i), .ce_i(ce_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .flush_o(flush),
        .flush_type_o(flush_type), .lat_upd_o(lat_upd), .lat_type_o(lat_type),
        .lat_ms_o(lat_ms), .rate_chg_o(rate_chg), .rate_type_o(rate_type),
        .rate_hz_o(rate_hz), .range_chg_o(range_chg), .acc_range_o(acc_r),
        .gyr_range_o(gyr_r), .mag_range_o(mag_r));

    ////////////////////
    // clock source
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // pulse counters
    always @(posedge mclk_i) begin
        n_flush <= n_flush + int'(flush === 1'b1);
        n_lat <= n_lat + int'(lat_upd === 1'b1);
        n_rate <= n_rate + int'(rate_chg === 1'b1);
        n_rng <= n_rng + int'(range_chg === 1'b1);
    end

    ////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        host.xfer(w, a, v, rd, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            complete_run();
        end
    endtask

    // select type, then one word
    task automatic pa(input logic w, input logic [7:0] b, input logic [7:0] t,
        input logic [3:0] ix, input logic [31:0] v);
        bus(1'b1, SEL_ADDR, {24'h0, t});
        bus(w, b + {2'b00, ix, 2'b00}, v);
    endtask

    task automatic settle();
        repeat (3) @(negedge mclk_i);
    endtask

    ////////////////////
    // main sequence
    initial begin
        ce_i = 1'b1;
        nrst_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        pa(1'b1, INFO_BASE, 8'h01, IX_MAXRNG, 32'hffff);
        foreach (ir[i]) begin
            pa(1'b0, INFO_BASE, ir[i].t, ir[i].ix, 32'h0);
            chk("info", rd, ir[i].e);
        end
        for (int i = 0; i < 16; i++) begin
            pa(1'b0, INFO_BASE, 8'h03, i[3:0], 32'h0);
            chk("unsupported", rd, 32'h0);
        end
        bus(1'b0, 8'hc0, 32'h0);
        chk("unmapped", rd, 32'h0);
        pa(1'b1, CFG_BASE, 8'h01, CX_SENS, 32'hbeef1234);
        pa(1'b0, CFG_BASE, 8'h01, CX_SENS, 32'h0);
        chk("sensitivity", rd, 32'h1234);
        // rate switch events
        foreach (rq[i]) begin
            k = 1;
            while (k < rq[i]) k = k * 2;
            pa(1'b1, CFG_BASE, 8'h01, CX_RATE, rq[i]);
            pa(1'b0, CFG_BASE, 8'h01, CX_RATE, 32'h0);
            if (i > 0) chk("old rate", rd, ph);
            for (int j = 0; j < 600 && n_rate < i + 1; j++) @(negedge mclk_i);
            chk("rate event", n_rate, i + 1);
            chk("rate type", rate_type, 8'h01);
            chk("rate", rate_hz, k);
            chk("window", int'(rate_hz * 10 >= rq[i] * 9 && rate_hz * 100 <= rq[i] * 210), 1);
            pa(1'b0, CFG_BASE, 8'h01, CX_RATE, 32'h0);
            chk("rate read", rd, k);
            ph = k[15:0];
        end
        // latency and flush
        k = n_lat;
        pa(1'b1, CFG_BASE, 8'h01, CX_LAT, 32'd500);
        settle();
        chk("lat pulse", n_lat, k + 1);
        chk("lat ms", lat_ms, 16'd500);
        chk("lat type", lat_type, 8'h01);
        pa(1'b0, CFG_BASE, 8'h01, CX_LAT, 32'h0);
        chk("lat read", rd, 32'd500);
        k = n_flush;
        pa(1'b1, CFG_BASE, 8'h01, CX_LAT, 32'h0);
        settle();
        chk("flush", n_flush, k + 1);
        chk("flush type", flush_type, 8'h01);
        pa(1'b1, CFG_BASE, 8'h01, CX_LAT, 32'h0);
        settle();
        chk("no flush", n_flush, k + 1);
        // shared range choice
        foreach (rr[i]) begin
            pa(1'b1, CFG_BASE, rr[i].t, CX_RANGE, 32'h0);
            pa(1'b1, CFG_BASE, rr[i].t | 8'h20, CX_RANGE, 32'h0);
        end
        settle();
        chk("acc default", acc_r, DEF_RNG[0]);
        k = n_rng;
        foreach (rr[i]) begin
            pa(1'b1, CFG_BASE, rr[i].t, CX_RANGE, rr[i].v);
            settle();
            ph = (rr[i].g == 2'h0) ? acc_r : (rr[i].g == 2'h1) ? gyr_r : mag_r;
            chk("phys range", ph, rr[i].e);
            pa(1'b0, CFG_BASE, rr[i].rb, CX_RANGE, 32'h0);
            chk("range read", rd, rr[i].e);
        end
        chk("range event", int'(n_rng - k >= 5), 1);
        // mid-run reset
        @(posedge mclk_i);
        nrst_i <= 1'b0;
        settle();
        chk("acc rst", acc_r, DEF_RNG[0]);
        chk("gyr rst", gyr_r, DEF_RNG[1]);
        chk("mag rst", mag_r, DEF_RNG[2]);
        chk("ready rst", hready, 1'b1);
        chk("okay", hresp, 1'b0);
        @(posedge mclk_i);
        nrst_i <= 1'b1;
        bus(1'b0, INFO_BASE, 32'h0);
        chk("type 0", rd, 32'h0);
        complete_run();
    end
endmodule
